/* File: hw/hpc_config_regs.sv */
// Hardware monitor and PECI configuration register bank on AHB-Lite
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`include "hpc_consts.svh"

module hpc_config_regs
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Strap pins, asynchronous to hclk
  input wire logic shared_pin_function_strap_pin,
  input wire logic fan_strap_pin,
  // Relative temperatures from the PECI engine, same clock
  input wire logic [15:0] agent_one_rel_temp,
  input wire logic [15:0] agent_two_rel_temp,
  // Hardware monitor controls
  output logic hardware_monitor_active,
  output logic [15:0] hardware_monitor_base,
  output logic hardware_monitor_base_valid,
  output logic [3:0] hardware_monitor_irq,
  // Pin function and fan start straps
  output logic shared_pin_function_strap,
  output logic fan_half_speed_strap,
  // PECI agent controls, bit 0 is agent 1
  output logic [3:0] agent_enable,
  output logic [3:0] agent_domain_one_select,
  output logic [3:0] agent_has_domain_one,
  output logic [6:0] agent_one_tbase,
  output logic [6:0] agent_two_tbase,
  output logic [6:0] agent_three_tbase,
  output logic [31:0] agent_client_addrs
);

  // Bus phase registers
  hpc_pkg::hpc_bus_state_t state_reg;
  hpc_pkg::hpc_bus_state_t state_next;
  logic [7:0] idx_reg;
  logic [7:0] idx_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  // Control registers
  logic activate_reg;
  logic activate_next;
  logic [7:0] base_high_reg;
  logic [7:0] base_high_next;
  logic [7:0] base_low_reg;
  logic [7:0] base_low_next;
  logic [3:0] irq_reg;
  logic [3:0] irq_next;
  logic [7:0] agent_cfg_reg;
  logic [7:0] agent_cfg_next;
  logic [3:0] presence_reg;
  logic [3:0] presence_next;
  logic readback_reg;
  logic readback_next;

  // Strap path
  logic [1:0] strap_meta_reg;
  logic [1:0] strap_sync_reg;
  logic [1:0] strap_val_reg;
  logic [1:0] strap_val_next;
  logic strap_done_reg;
  logic strap_done_next;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;

  // Address decode
  wire addr_upper_zero;
  wire addr_aligned;
  wire accept;
  wire [7:0] req_idx;
  wire write_phase;
  wire wr_activate;
  wire wr_base_high;
  wire wr_base_low;
  wire wr_irq;
  wire wr_agent_cfg;
  wire wr_tbase1;
  wire wr_tbase2;
  wire wr_tbase3;
  wire wr_domain;
  wire wr_readback;
  wire [7:0] wbyte;

  // Tcontrol read values
  wire [7:0] tbase1_rdata;
  wire [7:0] tbase2_rdata;
  wire [7:0] tbase3_rdata;
  wire [7:0] read_byte;
  wire [15:0] base_addr;

  // Request decode; the upper address bits outside the bank must be zero
  assign addr_upper_zero = (haddr[31:`HPC_ADDR_IDX_MSB+1] == 22'h00_0000);
  assign addr_aligned = (haddr[`HPC_ADDR_IDX_LSB-1:0] == 2'h0);
  assign accept = hsel & hready & htrans[1];
  assign req_idx = (addr_upper_zero & addr_aligned) ?
    haddr[`HPC_ADDR_IDX_MSB:`HPC_ADDR_IDX_LSB] : 8'hFF;
  assign write_phase = (state_reg == hpc_pkg::HPC_ST_WRITE);
  assign wbyte = hwdata[7:0];

  // Write strobes, one per writable register, during the write data phase
  assign wr_activate = write_phase & (idx_reg == `HPC_IDX_MON_ACTIVATE);
  assign wr_base_high = write_phase & (idx_reg == `HPC_IDX_MON_BASE_HIGH);
  assign wr_base_low = write_phase & (idx_reg == `HPC_IDX_MON_BASE_LOW);
  assign wr_irq = write_phase & (idx_reg == `HPC_IDX_MON_IRQ_SELECT);
  assign wr_agent_cfg = write_phase & (idx_reg == `HPC_IDX_AGENT_CONFIG);
  assign wr_tbase1 = write_phase & (idx_reg == `HPC_IDX_AGENT1_TBASE);
  assign wr_tbase2 = write_phase & (idx_reg == `HPC_IDX_AGENT2_TBASE);
  assign wr_tbase3 = write_phase & (idx_reg == `HPC_IDX_AGENT3_TBASE);
  assign wr_domain = write_phase & (idx_reg == `HPC_IDX_DOMAIN);
  assign wr_readback = write_phase & (idx_reg == `HPC_IDX_READBACK_MODE);

  // Reads get one wait state so a write just before is already visible
  always_comb
  begin
    state_next = hpc_pkg::HPC_ST_IDLE;
    idx_next = idx_reg;
    if (accept)
    begin
      state_next = hwrite ? hpc_pkg::HPC_ST_WRITE : hpc_pkg::HPC_ST_RWAIT;
      idx_next = req_idx;
    end
    else if (state_reg == hpc_pkg::HPC_ST_RWAIT)
      state_next = hpc_pkg::HPC_ST_RDATA;
  end

  // Only bit 0 is stored
  assign activate_next = wr_activate ? wbyte[`HPC_ACTIVATE_BIT] :
    activate_reg;

  // Base low bit 0 is forced to zero to keep the two-byte alignment
  assign base_high_next = wr_base_high ? wbyte : base_high_reg;
  assign base_low_next = wr_base_low ?
    {wbyte[7:1], 1'b0} : base_low_reg;

  // Only the low nibble selects an interrupt line
  assign irq_next = wr_irq ? wbyte[`HPC_IRQ_MSB:0] : irq_reg;

  // Enables in the high nibble, domain picks in the low nibble
  assign agent_cfg_next = wr_agent_cfg ? wbyte : agent_cfg_reg;

  // Presence bits live in the high nibble; low nibble is not stored
  assign presence_next = wr_domain ?
    wbyte[`HPC_PRESENCE_LSB+3:`HPC_PRESENCE_LSB] : presence_reg;
  assign readback_next = wr_readback ? wbyte[`HPC_READBACK_BIT] :
    readback_reg;

  // Bus state and address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= hpc_pkg::HPC_ST_IDLE;
      idx_reg <= `HPC_RST_BYTE;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // Control registers, all cleared at reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      activate_reg <= 1'b0;
      base_high_reg <= `HPC_RST_BYTE;
      base_low_reg <= `HPC_RST_BYTE;
      irq_reg <= 4'h0;
      agent_cfg_reg <= `HPC_RST_BYTE;
      presence_reg <= 4'h0;
      readback_reg <= 1'b0;
    end
    else
    begin
      activate_reg <= activate_next;
      base_high_reg <= base_high_next;
      base_low_reg <= base_low_next;
      irq_reg <= irq_next;
      agent_cfg_reg <= agent_cfg_next;
      presence_reg <= presence_next;
      readback_reg <= readback_next;
    end
  end

  // Strap synchroniser; the first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_meta_reg <= 2'h0;
      strap_sync_reg <= 2'h0;
    end
    else
    begin
      strap_meta_reg <= {shared_pin_function_strap_pin, fan_strap_pin};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Wait for the synchroniser to fill, then latch once and hold
  assign settle_next = (settle_reg == `HPC_STRAP_SETTLE) ?
    settle_reg : settle_reg + 2'h1;
  assign strap_done_next = strap_done_reg |
    (settle_reg == `HPC_STRAP_SETTLE);
  assign strap_val_next = (!strap_done_reg &&
    (settle_reg == `HPC_STRAP_SETTLE)) ? strap_sync_reg : strap_val_reg;

  // Strap capture state; a constant under reset, value taken afterwards
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      settle_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_val_reg <= 2'h0;
    end
    else
    begin
      settle_reg <= settle_next;
      strap_done_reg <= strap_done_next;
      strap_val_reg <= strap_val_next;
    end
  end

  // Tcontrol registers; alternate bytes per readback mode
  hpc_tcontrol_reg u_tbase1
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_tbase1),
    .wdata(wbyte),
    .readback_mode(readback_reg),
    .alt_byte(agent_one_rel_temp[15:8]),
    .rdata(tbase1_rdata),
    .tbase(agent_one_tbase)
  );

  hpc_tcontrol_reg u_tbase2
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_tbase2),
    .wdata(wbyte),
    .readback_mode(readback_reg),
    .alt_byte(agent_two_rel_temp[7:0]),
    .rdata(tbase2_rdata),
    .tbase(agent_two_tbase)
  );

  hpc_tcontrol_reg u_tbase3
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_tbase3),
    .wdata(wbyte),
    .readback_mode(readback_reg),
    .alt_byte(agent_two_rel_temp[15:8]),
    .rdata(tbase3_rdata),
    .tbase(agent_three_tbase)
  );

  // Read mux; reserved bits and unmapped indices read zero
  assign read_byte =
    (idx_reg == `HPC_IDX_MON_ACTIVATE) ? {7'h00, activate_reg} :
    (idx_reg == `HPC_IDX_MON_BASE_HIGH) ? base_high_reg :
    (idx_reg == `HPC_IDX_MON_BASE_LOW) ? base_low_reg :
    (idx_reg == `HPC_IDX_MON_IRQ_SELECT) ? {4'h0, irq_reg} :
    (idx_reg == `HPC_IDX_AGENT_CONFIG) ? (readback_reg ?
      agent_one_rel_temp[7:0] : agent_cfg_reg) :
    (idx_reg == `HPC_IDX_AGENT1_TBASE) ? tbase1_rdata :
    (idx_reg == `HPC_IDX_AGENT2_TBASE) ? tbase2_rdata :
    (idx_reg == `HPC_IDX_AGENT3_TBASE) ? tbase3_rdata :
    (idx_reg == `HPC_IDX_DOMAIN) ? {presence_reg, 4'h0} :
    (idx_reg == `HPC_IDX_READBACK_MODE) ? {4'h0, readback_reg, 3'h0} :
    (idx_reg == `HPC_IDX_STRAP_STATUS) ?
      {6'h00, strap_val_reg} : 8'h00;

  // Read data loaded in the wait cycle, held until the next read
  assign hrdata_next = (state_reg == hpc_pkg::HPC_ST_RWAIT) ?
    {24'h00_0000, read_byte} : hrdata_reg;

  // Bus answers; always OKAY, stall only in the read wait cycle
  assign hrdata = hrdata_reg;
  assign hreadyout = (state_reg != hpc_pkg::HPC_ST_RWAIT);
  assign hresp = 1'b0;

  // Monitor controls; base valid only inside the allowed window
  assign base_addr = {base_high_reg, base_low_reg};
  assign hardware_monitor_active = activate_reg;
  assign hardware_monitor_base = base_addr;
  assign hardware_monitor_base_valid = (base_addr >= `HPC_BASE_MIN) &&
    (base_addr <= `HPC_BASE_MAX);
  assign hardware_monitor_irq = irq_reg;

  // Strap outputs straight from the latched values
  assign shared_pin_function_strap =
    strap_val_reg[`HPC_STRAP_SHARED_BIT];
  assign fan_half_speed_strap = strap_val_reg[`HPC_STRAP_FAN_BIT];

  // Agent controls; domain pick gated by presence
  assign agent_enable = agent_cfg_reg[`HPC_AGENT_EN_LSB+3:`HPC_AGENT_EN_LSB];
  assign agent_has_domain_one = presence_reg;
  assign agent_domain_one_select =
    agent_cfg_reg[`HPC_DOMAIN_SEL_LSB+3:`HPC_DOMAIN_SEL_LSB] &
    presence_reg;

  // Client addresses in agent order, agent 1 in the low byte
  assign agent_client_addrs = {`HPC_CLIENT_ADDR_BASE + 8'h03,
    `HPC_CLIENT_ADDR_BASE + 8'h02, `HPC_CLIENT_ADDR_BASE + 8'h01,
    `HPC_CLIENT_ADDR_BASE};

endmodule : hpc_config_regs

/* File: hw/hpc_consts.svh */
// Offsets, field positions, reset values and counts for the config bank
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index
`define HPC_IDX_MON_ACTIVATE 8'h30
`define HPC_IDX_MON_BASE_HIGH 8'h60
`define HPC_IDX_MON_BASE_LOW 8'h61
`define HPC_IDX_MON_IRQ_SELECT 8'h70
`define HPC_IDX_AGENT_CONFIG 8'hE0
`define HPC_IDX_AGENT1_TBASE 8'hE1
`define HPC_IDX_AGENT2_TBASE 8'hE2
`define HPC_IDX_AGENT3_TBASE 8'hE3
`define HPC_IDX_DOMAIN 8'hE5
`define HPC_IDX_READBACK_MODE 8'hE8
`define HPC_IDX_STRAP_STATUS 8'hF2

// Address decode: index in haddr[9:2], everything above must be zero
`define HPC_ADDR_IDX_LSB 2
`define HPC_ADDR_IDX_MSB 9

// Reset values
`define HPC_RST_BYTE 8'h00
`define HPC_RST_TBASE 7'h48

// Field positions
`define HPC_ACTIVATE_BIT 0
`define HPC_BASE_ALIGN_BIT 0
`define HPC_IRQ_MSB 3
`define HPC_AGENT_EN_LSB 4
`define HPC_DOMAIN_SEL_LSB 0
`define HPC_PRESENCE_LSB 4
`define HPC_READBACK_BIT 3
`define HPC_STRAP_SHARED_BIT 1
`define HPC_STRAP_FAN_BIT 0

// Monitor base address window
`define HPC_BASE_MIN 16'h0100
`define HPC_BASE_MAX 16'h0FFE

// Client address of agent 1; agents 2..4 follow in order
`define HPC_CLIENT_ADDR_BASE 8'h30

// Cycles after reset release before straps are latched
`define HPC_STRAP_SETTLE 2'h3

`endif

/* File: hw/hpc_pkg.sv */
// Types shared by the hardware monitor and PECI configuration bank
package hpc_pkg;

  // Bus slave phase tracking
  typedef enum logic [1:0] {
    HPC_ST_IDLE,
    HPC_ST_WRITE,
    HPC_ST_RWAIT,
    HPC_ST_RDATA
  } hpc_bus_state_t;

endpackage : hpc_pkg

/* File: hw/hpc_tcontrol_reg.sv */
// One agent Tcontrol register with relative temperature readback
`timescale 1ns/10ps
`include "hpc_consts.svh"

module hpc_tcontrol_reg
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Write side
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  // Readback selection
  input wire logic readback_mode,
  input wire logic [7:0] alt_byte,
  // Results
  output logic [7:0] rdata,
  output logic [6:0] tbase
);

  logic [6:0] tbase_reg;
  logic [6:0] tbase_next;

  // Bit 7 is never stored; only Tbase bits take the write
  assign tbase_next = wr_en ? wdata[6:0] : tbase_reg;

  // Reset default of the Tbase field
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tbase_reg <= `HPC_RST_TBASE;
    else
      tbase_reg <= tbase_next;
  end

  // Alternate mode shows a temperature byte instead of Tbase
  assign rdata = readback_mode ? alt_byte : {1'b0, tbase_reg};
  assign tbase = tbase_reg;

endmodule : hpc_tcontrol_reg

/* File: tb/hpc_config_regs_chk.sv */
// Port-level concurrent checks for the config register bank
`timescale 1ns/10ps
module hpc_config_regs_chk
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Controls
  input wire logic hardware_monitor_active,
  input wire logic [15:0] hardware_monitor_base,
  input wire logic hardware_monitor_base_valid,
  input wire logic shared_pin_function_strap,
  input wire logic fan_half_speed_strap,
  input wire logic [3:0] agent_enable,
  input wire logic [3:0] agent_domain_one_select,
  input wire logic [3:0] agent_has_domain_one,
  input wire logic [6:0] agent_one_tbase,
  input wire logic [31:0] agent_client_addrs
);
  logic [2:0] strap_age;
  // Address phase taken; reads and writes split below
  wire logic req = hsel && hready && htrans[1];
  wire logic wreq = req && hwrite;
  wire logic rreq = req && !hwrite;

  // Saturating age since release; straps are settled well before 7
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      strap_age <= 3'h0;
    else if (strap_age != 3'h7)
      strap_age <= strap_age + 3'h1;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_act_write: assert property (wreq && haddr == 32'h0000_00C0 |=>
    ##1 hardware_monitor_active == $past(hwdata[0]))
    else $error("activate bit did not follow write");
  a_base_even: assert property (!hardware_monitor_base[0])
    else $error("monitor base is odd");
  a_base_window: assert property (hardware_monitor_base_valid ==
    (hardware_monitor_base >= 16'h0100 && hardware_monitor_base <= 16'h0FFE))
    else $error("base valid flag disagrees with window");
  a_irq_resv: assert property (rreq && haddr == 32'h0000_01C0 |=>
    ##1 hrdata[7:4] == 4'h0)
    else $error("irq register upper bits not zero");
  a_strap_read: assert property (
    rreq && haddr == 32'h0000_03C8 && strap_age == 3'h7 |=> ##1 hrdata ==
    {30'h0, shared_pin_function_strap, fan_half_speed_strap})
    else $error("strap read differs from strap outputs");
  a_en_write: assert property (wreq && haddr == 32'h0000_0380 |=>
    ##1 agent_enable == $past(hwdata[7:4]))
    else $error("agent enables did not follow write");
  a_domain_gate: assert property (
    (agent_domain_one_select & ~agent_has_domain_one) == 4'h0)
    else $error("domain pick active without presence");
  a_client_map: assert property (
    agent_client_addrs == 32'h3332_3130)
    else $error("client address map wrong");
  a_tbase_write: assert property (
    wreq && haddr == 32'h0000_0384 |=>
    ##1 agent_one_tbase == $past(hwdata[6:0]))
    else $error("agent one tbase did not follow write");
  a_rdata_resv: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_strap_held: assert property (strap_age == 3'h7 |->
    $stable({shared_pin_function_strap, fan_half_speed_strap}))
    else $error("strap outputs changed after latching");
endmodule : hpc_config_regs_chk

bind hpc_config_regs hpc_config_regs_chk hpc_config_regs_chk_i (.hclk,
  .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hardware_monitor_active, .hardware_monitor_base,
  .hardware_monitor_base_valid, .shared_pin_function_strap,
  .fan_half_speed_strap, .agent_enable, .agent_domain_one_select,
  .agent_has_domain_one, .agent_one_tbase, .agent_client_addrs);

/* File: tb/tb_hpc_config_regs.sv */
// Self-checking bench for the config register bank
`timescale 1ns/10ps
module tb_hpc_config_regs;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic sh_pin = 1'b1;
  logic fan_pin = 1'b0;
  logic [15:0] t1 = 16'hBEEF;
  logic [15:0] t2 = 16'hCAFE;
  logic [31:0] hrdata, caddr, rv;
  logic hreadyout, hresp, act, bval, sh, fh;
  logic [15:0] base;
  logic [3:0] irq, en, dsel, dhas;
  logic [6:0] tb1, tb2, tb3;
  int mismatches = 0;
  int checks = 0;
  logic [7:0] ridx [7] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hE0, 8'hE1, 8'hE2};
  logic [7:0] rexp [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h48, 8'h48};
  logic [7:0] bhi [4] = '{8'h01, 8'h0F, 8'h00, 8'h10};
  logic [7:0] blo [4] = '{8'h00, 8'hFF, 8'hFE, 8'h00};
  logic bok [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0] aidx [4] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3};
  logic [7:0] aexp [4] = '{8'hEF, 8'hBE, 8'hFE, 8'hCA};

  hpc_config_regs hpc_config_regs_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .shared_pin_function_strap_pin(sh_pin), .fan_strap_pin(fan_pin),
    .agent_one_rel_temp(t1), .agent_two_rel_temp(t2),
    .hardware_monitor_active(act), .hardware_monitor_base(base),
    .hardware_monitor_base_valid(bval), .hardware_monitor_irq(irq),
    .shared_pin_function_strap(sh), .fan_half_speed_strap(fh),
    .agent_enable(en), .agent_domain_one_select(dsel),
    .agent_has_domain_one(dhas), .agent_one_tbase(tb1),
    .agent_two_tbase(tb2), .agent_three_tbase(tb3),
    .agent_client_addrs(caddr));

  // Free-running bus clock
  always #4 hclk = ~hclk;

  task automatic results;
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Wait for hready high at an edge; sampled at negedge to avoid races
  task automatic wt(output logic [31:0] d);
    int n;
    logic r;
    n = 0;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
      n++;
    end
    while (r !== 1'b1 && n < 20);
    if (r !== 1'b1)
    begin
      mismatches++;
      results();
    end
  endtask : wt

  // One single transfer; upper write bits are junk the bank must ignore
  task automatic bus(input logic [31:0] a, input logic w,
    input logic [7:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wt(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'hFF_FFFF, wd};
    wt(d);
    // Outputs launched at that edge are settled by the falling edge
    @(negedge hclk);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus({22'h0, idx, 2'h0}, 1'b1, wd, rv);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus({22'h0, idx, 2'h0}, 1'b0, 8'h00, rv);
    chk(rv, {24'h00_0000, e});
  endtask : rd

  // Reset long enough for the straps to settle before the first read
  task automatic rst;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : rst

  // Main sequence; every Tbase stored is positive
  initial
  begin
    rst();
    foreach (ridx[i])
      rd(ridx[i], rexp[i]);
    rd(8'hF2, 8'h02);
    chk(32'({sh, fh}), 32'h2);
    // Flip the pins; the latched straps must not follow
    @(posedge hclk);
    sh_pin <= 1'b0;
    fan_pin <= 1'b1;
    wr(8'hF2, 8'hFF);
    rd(8'hF2, 8'h02);
    chk(32'({sh, fh}), 32'h2);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h01);
    chk(32'(act), 32'h1);
    wr(8'h30, 8'h00);
    chk(32'(act), 32'h0);
    foreach (bhi[i])
    begin
      wr(8'h60, bhi[i]);
      wr(8'h61, blo[i]);
      chk(32'({bval, base}),
        {15'h0, bok[i], bhi[i], blo[i] & 8'hFE});
    end
    wr(8'h61, 8'hFF);
    rd(8'h61, 8'hFE);
    wr(8'h70, 8'hA5);
    rd(8'h70, 8'h05);
    chk(32'(irq), 32'h5);
    wr(8'hE0, 8'hA5);
    chk(32'({en, dsel}), 32'hA0);
    wr(8'hE5, 8'hFF);
    rd(8'hE5, 8'hF0);
    chk(32'({dhas, dsel}), 32'hF5);
    wr(8'hE5, 8'h30);
    chk(32'(dsel), 32'h1);
    chk(caddr, 32'h3332_3130);
    // Bit 7 set on the bus only; the stored Tbase stays positive
    wr(8'hE1, 8'hBF);
    wr(8'hE2, 8'h35);
    wr(8'hE3, 8'h12);
    chk(32'({tb3, tb2, tb1}),
      {11'h0, 7'h12, 7'h35, 7'h3F});
    rd(8'hE1, 8'h3F);
    wr(8'hE8, 8'h08);
    rd(8'hE8, 8'h08);
    foreach (aidx[i]) rd(aidx[i], aexp[i]);
    wr(8'hE1, 8'h22);
    wr(8'hE8, 8'h00);
    rd(8'hE1, 8'h22);
    rd(8'hE0, 8'hA5);
    bus(32'h0000_0400, 1'b0, 8'h00, rv);
    chk(rv, 32'h0000_0000);
    chk(32'(hresp), 32'h0);
    rd(8'hF0, 8'h00);
    rst();
    rd(8'hF2, 8'h01);
    chk(32'({sh, fh}), 32'h1);
    rd(8'hE1, 8'h48);
    results();
  end
endmodule : tb_hpc_config_regs
